// ### verilog/imd_pkg.sv
// package: constants and carrier types for the internal memory map decoder
package imd_pkg;
  localparam int          ADDR_W        = 32;
  localparam logic [31:0] BLOCK_SIZE    = 32'h0040_0000; // 4-Mbyte block
  localparam int          BLOCK_SHIFT   = 22;
  localparam int          BASE_SEL_W    = 3;              // eight candidate bases
  localparam int          OFF_W         = 22;
  // region offsets within the block
  localparam logic [21:0] FLASH_A_LO    = 22'h00_0000;
  localparam logic [21:0] FLASH_A_HI    = 22'h07_FFFF;
  localparam logic [21:0] FLASH_B_HI    = 22'h0F_FFFF;
  localparam logic [21:0] FLASH_RSV_HI  = 22'h2F_7FFF;
  localparam logic [21:0] DECOMPRESSION_RAM_LO     = 22'h2F_8000;
  localparam logic [21:0] DECOMPRESSION_RAM_HI     = 22'h2F_8FFF;
  localparam logic [21:0] BBU_CTL_LO    = 22'h2F_A000;
  localparam logic [21:0] BBU_CTL_HI    = 22'h2F_BFFF;
  localparam logic [21:0] SIU_CTL_LO    = 22'h2F_C000;
  localparam logic [21:0] SIU_CTL_HI    = 22'h2F_FFFF;
  localparam logic [21:0] IMB_LO        = 22'h30_0000;
  localparam logic [21:0] IMB_HI        = 22'h30_7FFF;
  localparam logic [21:0] LCTL_LO       = 22'h38_0000;
  localparam logic [21:0] LCTL_HI       = 22'h38_00FF;
  localparam logic [21:0] LCTL_RSV_LO   = 22'h38_0100;
  localparam logic [21:0] LCTL_RSV_HI   = 22'h38_3FFF;
  localparam logic [21:0] CAL_LO        = 22'h3F_7000;
  localparam logic [21:0] CAL_HI        = 22'h3F_FFFF;   // 36 Kbytes
  localparam int          CAL_BLK_SHIFT = 13;             // 8-Kbyte protection blocks
  localparam int          CAL_BLK_W     = 3;              // blocks over 0x3F0000..0x3FFFFF
  localparam int          SPR_WAIT      = 2;              // burst-buffer register cycles

  typedef enum logic [3:0] {
    IMD_TGT_NONE, IMD_TGT_FLASH_A, IMD_TGT_FLASH_B, IMD_TGT_DECOMPRESSION_RAM, IMD_TGT_BBU_CTL,
    IMD_TGT_SIU_CTL, IMD_TGT_IMB, IMD_TGT_LCTL, IMD_TGT_CALIBRATION_SRAM, IMD_TGT_RESERVED, IMD_TGT_EXTERNAL
  } imd_target_t;

  typedef enum logic [1:0] {IMD_EXC_NONE, IMD_EXC_DSI, IMD_EXC_MCHK} imd_exc_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              from_core;
    logic              overlay;
    logic              data_reloc;
  } imd_req_t;

  typedef struct packed {
    logic              valid;
    imd_target_t       target;
    logic [OFF_W-1:0]  offset;
    logic              error;
    imd_exc_t          exc;
  } imd_rsp_t;

  typedef enum logic {IMD_ST_IDLE, IMD_ST_SPR} imd_phase_t;
endpackage

// ### verilog/imd_decoder.sv
// internal memory map decoder: region select, wait for burst-buffer registers, exception pick
//
// Contract
// - decode one 4-Mbyte relocatable internal block
// - base is one of first eight aligned blocks
// - flash halves low, then reserved flash area
// - calibration sram routed to the L-bus
// - 32-Kbyte control area in three parts
// - burst-buffer and system-integration control ranges
// - bridge peripherals in 32-Kbyte window
// - 256-byte L-bus control window
// - L-bus control remainder is reserved
// - 4-Kbyte decompression ram mapped as memory
// - burst-buffer register accesses take two cycles
// - calibration sram protection in 8-Kbyte blocks
// - disallowed core non-overlay access gives data-storage
// - overlay or non-core disallowed gives machine-check
// - data-storage only while data-relocation bit set
`timescale 1ns/1ps
module imd_decoder
  import imd_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET,
  input  wire logic [BASE_SEL_W-1:0] BASE_SEL,
  input  wire logic                  REQ_VALID,
  input  wire imd_req_t              REQ,
  input  wire logic [7:0]            CAL_PROTECT,
  output logic                       REQ_READY,
  output imd_rsp_t                   RSP,
  output logic                       EXT_VALID,
  output logic [ADDR_W-1:0]          EXT_ADDR
);

  typedef struct packed {
    imd_phase_t          phase;
    imd_req_t            held;
    logic                ready;
    imd_rsp_t            rsp;
    logic                ext_valid;
    logic [ADDR_W-1:0]   ext_addr;
  } imd_state_t;

  imd_state_t st_q;
  imd_state_t st_d;

  // inclusive range test on block offsets, used for every region except the upper flash half and reserved flash area
  function automatic logic in_rng(input logic [OFF_W-1:0] o, input logic [OFF_W-1:0] lo,
                                  input logic [OFF_W-1:0] hi);
    in_rng = (o >= lo) && (o <= hi);
  endfunction

  // region lookup; gaps inside the block fall to reserved so they can never reach a target
  function automatic imd_target_t region(input logic [OFF_W-1:0] o);
    if (in_rng(o, FLASH_A_LO, FLASH_A_HI))       region = IMD_TGT_FLASH_A;
    else if (o <= FLASH_B_HI)                    region = IMD_TGT_FLASH_B;
    else if (o <= FLASH_RSV_HI)                  region = IMD_TGT_RESERVED;
    else if (in_rng(o, DECOMPRESSION_RAM_LO, DECOMPRESSION_RAM_HI))    region = IMD_TGT_DECOMPRESSION_RAM;
    else if (in_rng(o, BBU_CTL_LO, BBU_CTL_HI))  region = IMD_TGT_BBU_CTL;
    else if (in_rng(o, SIU_CTL_LO, SIU_CTL_HI))  region = IMD_TGT_SIU_CTL;
    else if (in_rng(o, IMB_LO, IMB_HI))          region = IMD_TGT_IMB;
    else if (in_rng(o, LCTL_LO, LCTL_HI))        region = IMD_TGT_LCTL;
    else if (in_rng(o, LCTL_RSV_LO, LCTL_RSV_HI)) region = IMD_TGT_RESERVED;
    else if (in_rng(o, CAL_LO, CAL_HI))          region = IMD_TGT_CALIBRATION_SRAM;
    else                                         region = IMD_TGT_RESERVED;
  endfunction

  logic [OFF_W-1:0]     off;
  logic                 hit;
  imd_target_t          tgt;
  logic [CAL_BLK_W-1:0] cal_blk;
  logic                 cal_deny;
  imd_exc_t             exc;

  // the block claims an address only when its top bits match the chosen base
  assign hit = (REQ.addr[ADDR_W-1:BLOCK_SHIFT] == {{(ADDR_W-BLOCK_SHIFT-BASE_SEL_W){1'h0}}, BASE_SEL});
  assign off = REQ.addr[OFF_W-1:0];
  assign tgt = hit ? region(off) : IMD_TGT_EXTERNAL;
  // one protection bit per 8-Kbyte block of the calibration area
  assign cal_blk  = off[CAL_BLK_SHIFT+CAL_BLK_W-1:CAL_BLK_SHIFT];
  assign cal_deny = (tgt == IMD_TGT_CALIBRATION_SRAM) && CAL_PROTECT[cal_blk];

  // exception choice; core non-overlay denial is silent unless data relocation is on
  always_comb begin
    exc = IMD_EXC_NONE;
    if (cal_deny) begin
      if (REQ.overlay || !REQ.from_core) begin
        exc = IMD_EXC_MCHK;
      end else if (REQ.data_reloc) begin
        exc = IMD_EXC_DSI;
      end
    end
  end

  // next state: one answer per taken request, burst-buffer registers answered a cycle late
  always_comb begin
    st_d               = st_q;
    st_d.rsp.valid     = 1'h0;
    st_d.ext_valid     = 1'h0;
    unique case (st_q.phase)
      IMD_ST_IDLE: begin
        if (REQ_VALID && st_q.ready) begin
          if (tgt == IMD_TGT_EXTERNAL) begin
            st_d.ext_valid = 1'h1;
            st_d.ext_addr  = REQ.addr;
          end else if (tgt == IMD_TGT_BBU_CTL) begin
            // park the request; the previous answer fields stand until the late answer replaces them
            st_d.phase = IMD_ST_SPR;
            st_d.held  = REQ;
            st_d.ready = 1'h0;
          end else begin
            st_d.rsp.valid  = 1'h1;
            st_d.rsp.target = tgt;
            st_d.rsp.offset = off;
            st_d.rsp.error  = (tgt == IMD_TGT_RESERVED) || cal_deny;
            st_d.rsp.exc    = exc;
          end
        end
      end
      IMD_ST_SPR: begin
        // second cycle: answer from the parked request and reopen the port
        // requests in the wait are refused, not queued, so no buffer is needed
        st_d.phase      = IMD_ST_IDLE;
        st_d.ready      = 1'h1;
        st_d.rsp.valid  = 1'h1;
        st_d.rsp.target = IMD_TGT_BBU_CTL;
        st_d.rsp.offset = st_q.held.addr[OFF_W-1:0];
        st_d.rsp.error  = 1'h0;
        st_d.rsp.exc    = IMD_EXC_NONE;
      end
    endcase
  end

  // single register stage holds the whole state
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_q       <= '0;
      st_q.phase <= IMD_ST_IDLE;
      st_q.ready <= 1'h1;
    end else begin
      st_q <= st_d;
    end
  end

  assign REQ_READY = st_q.ready;
  assign RSP       = st_q.rsp;
  assign EXT_VALID = st_q.ext_valid;
  assign EXT_ADDR  = st_q.ext_addr;

  // a request that the block claims in this cycle, shared by the checks below
  logic take_in;
  assign take_in = REQ_VALID && REQ_READY && hit;

  // checks
  // burst-buffer register access: taken, one silent cycle with the port closed, then the answer
  sequence s_spr_take;
    REQ_VALID && REQ_READY && (tgt == IMD_TGT_BBU_CTL);
  endsequence
  sequence s_spr_answer;
    (!RSP.valid && !REQ_READY) ##1 (RSP.valid && REQ_READY && (RSP.target == IMD_TGT_BBU_CTL));
  endsequence

  a_spr_two_cycle: assert property (@(posedge CLK_SYS) disable iff (RESET)
    s_spr_take |=> s_spr_answer)
    else $error("burst-buffer register answer not at second cycle");
  a_spr_offset: assert property (@(posedge CLK_SYS) disable iff (RESET)
    s_spr_take |=> ##1 (RSP.offset == $past(REQ.addr[OFF_W-1:0], 2)))
    else $error("late burst-buffer answer carries the wrong offset");
  // a refused request must leave no trace; the late answer is all that shows
  a_refused_idle: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REQ_VALID && !REQ_READY) |=> (!EXT_VALID && RSP.valid && (RSP.target == IMD_TGT_BBU_CTL)))
    else $error("request decoded while the port was closed");

  // claim of the chosen block and pass-on of everything else
  a_external_pass: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REQ_VALID && REQ_READY && !hit) |=> (EXT_VALID && !RSP.valid && EXT_ADDR == $past(REQ.addr)))
    else $error("outside address not passed on");
  a_base_claim: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REQ_VALID && REQ_READY && (REQ.addr[ADDR_W-1:BLOCK_SHIFT+BASE_SEL_W] == '0)
      && (REQ.addr[BLOCK_SHIFT+BASE_SEL_W-1:BLOCK_SHIFT] == BASE_SEL))
      |=> (!EXT_VALID && (RSP.valid || !REQ_READY)))
    else $error("address inside the chosen block not claimed");
  a_offset_carry: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && tgt != IMD_TGT_BBU_CTL) |=> (RSP.valid && RSP.offset == $past(REQ.addr[OFF_W-1:0])))
    else $error("block offset not carried with the answer");

  // flash area: two halves, then the reserved remainder
  a_flash_half: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off <= FLASH_A_HI) |=> (RSP.target == IMD_TGT_FLASH_A && !RSP.error))
    else $error("lower flash half misrouted");
  a_flash_upper: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off > FLASH_A_HI && off <= FLASH_B_HI) |=> (RSP.target == IMD_TGT_FLASH_B && !RSP.error))
    else $error("upper flash half misrouted");
  a_flash_rsv: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off > FLASH_B_HI && off <= FLASH_RSV_HI) |=> (RSP.error && RSP.target == IMD_TGT_RESERVED))
    else $error("reserved flash area not refused");

  // memory and control windows above the flash
  a_decompression_ram_map: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off >= DECOMPRESSION_RAM_LO && off <= DECOMPRESSION_RAM_HI) |=> (RSP.target == IMD_TGT_DECOMPRESSION_RAM && !RSP.error))
    else $error("decompression ram not mapped");
  a_siu_window: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off >= SIU_CTL_LO && off <= SIU_CTL_HI) |=> (RSP.target == IMD_TGT_SIU_CTL && !RSP.error))
    else $error("system-integration control range misrouted");
  a_imb_window: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off >= IMB_LO && off <= IMB_HI) |=> (RSP.target == IMD_TGT_IMB && !RSP.error))
    else $error("bridge peripheral window misrouted");
  a_lctl_window: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off >= LCTL_LO && off <= LCTL_HI) |=> (RSP.target == IMD_TGT_LCTL && !RSP.error))
    else $error("L-bus control window misrouted");
  a_reserved_err: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off >= LCTL_RSV_LO && off <= LCTL_RSV_HI) |=> (RSP.valid && RSP.error))
    else $error("reserved control hit without error");
  a_gap_err: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off > IMB_HI && off < LCTL_LO) |=> (RSP.valid && RSP.error && RSP.target == IMD_TGT_RESERVED))
    else $error("gap above the bridge window not refused");

  // calibration area: routing, per-block protection and the exception pick
  a_cal_route: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && off >= CAL_LO)
      |=> (RSP.target == IMD_TGT_CALIBRATION_SRAM && RSP.error == $past(CAL_PROTECT[off[CAL_BLK_SHIFT +: CAL_BLK_W]])))
    else $error("calibration access misrouted or wrongly protected");
  a_mchk_pick: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REQ_VALID && REQ_READY && cal_deny && (REQ.overlay || !REQ.from_core)) |=> (RSP.exc == IMD_EXC_MCHK))
    else $error("machine-check not raised");
  a_dsi_pick: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REQ_VALID && REQ_READY && cal_deny && !REQ.overlay && REQ.from_core)
      |=> (RSP.exc == ($past(REQ.data_reloc) ? IMD_EXC_DSI : IMD_EXC_NONE)))
    else $error("data-storage choice wrong");
  a_exc_clean: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take_in && !cal_deny && tgt != IMD_TGT_BBU_CTL) |=> (RSP.exc == IMD_EXC_NONE))
    else $error("exception raised for an allowed access");
endmodule

// ### test/imd_core_model.sv
// core-side master model: drives requests and holds them until taken
`timescale 1ns/1ps
module imd_core_model
  import imd_pkg::*;
(
  input  wire logic CLK_SYS,
  input  wire logic REQ_READY,
  output logic      REQ_VALID,
  output imd_req_t  REQ
);
  initial begin
    REQ_VALID = 1'h0;
    REQ       = '0;
  end
  // called just after a falling edge; ok stays low if never taken within 8 edges
  task automatic send(input imd_req_t r, output logic ok);
    ok        = 1'h0;
    REQ_VALID = 1'h1;
    REQ       = r;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge CLK_SYS);
      ok = (REQ_READY === 1'h1);
    end
  endtask
  // released bus shows the inverse so a stale address is never mistaken for a live one
  task automatic idle();
    REQ_VALID = 1'h0;
    REQ       = ~REQ;
  endtask
endmodule

// ### test/internal_memory_map_decoder_test.sv
// self-checking bench: decoder against a behavioural map model
`timescale 1ns/1ps
module internal_memory_map_decoder_test
  import imd_pkg::*;
;
  typedef struct packed {
    logic rv; logic xv; logic rdy0; imd_target_t t; logic er; imd_exc_t x; logic [21:0] o; logic [31:0] xa;
  } imd_exp_t;
  logic CLK_SYS, RESET, REQ_VALID, REQ_READY, EXT_VALID, ok;
  logic [2:0] BASE_SEL;
  logic [7:0] CAL_PROTECT;
  logic [31:0] EXT_ADDR;
  imd_req_t REQ;
  imd_rsp_t RSP;
  imd_exp_t ex [8];
  imd_exp_t e;
  logic [15:0] lf = 16'h0038;
  logic [15:0] r1, r2;
  logic [21:0] off;
  int cyc = 0, n_mismatch = 0, checks_done = 0;
  // region edges and the gaps between them
  logic [21:0] tbl [26] = '{22'h00_0000, 22'h07_FFFF, 22'h08_0000, 22'h0F_FFFF, 22'h10_0000, 22'h2F_7FFF,
    22'h2F_8000, 22'h2F_8FFF, 22'h2F_9000, 22'h2F_9FFF, 22'h2F_A000, 22'h2F_BFFF, 22'h2F_C000, 22'h2F_FFFF,
    22'h30_0000, 22'h30_7FFF, 22'h30_8000, 22'h37_FFFF, 22'h38_0000, 22'h38_00FF, 22'h38_0100, 22'h38_3FFF,
    22'h38_4000, 22'h3F_6FFF, 22'h3F_7000, 22'h3F_FFFF};
  imd_decoder i_dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .BASE_SEL(BASE_SEL), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .CAL_PROTECT(CAL_PROTECT), .REQ_READY(REQ_READY), .RSP(RSP), .EXT_VALID(EXT_VALID), .EXT_ADDR(EXT_ADDR));
  imd_core_model i_core (.CLK_SYS(CLK_SYS), .REQ_READY(REQ_READY), .REQ_VALID(REQ_VALID), .REQ(REQ));
  initial begin
    CLK_SYS = 1'h0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input string what, input logic [31:0] ev, input logic [31:0] sv);
    checks_done++;
    if (ev !== sv) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, ev, sv);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // map model: offsets and exception choice worked out from the memory map
  function automatic void predict(input imd_req_t q, output imd_exp_t p);
    logic [21:0] o;
    o = q.addr[21:0];
    p = '0;
    p.o = o;
    p.rv = 1'h1;
    if (q.addr[31:22] !== {7'h00, BASE_SEL}) begin
      p.rv = 1'h0;
      p.xv = 1'h1;
      p.xa = q.addr;
    end else if (o <= 22'h0F_FFFF) p.t = o[19] ? IMD_TGT_FLASH_B : IMD_TGT_FLASH_A;
    else if (o >= 22'h2F_8000 && o <= 22'h2F_8FFF) p.t = IMD_TGT_DECOMPRESSION_RAM;
    else if (o >= 22'h2F_A000 && o <= 22'h2F_BFFF) p.t = IMD_TGT_BBU_CTL;
    else if (o >= 22'h2F_C000 && o <= 22'h2F_FFFF) p.t = IMD_TGT_SIU_CTL;
    else if (o >= 22'h30_0000 && o <= 22'h30_7FFF) p.t = IMD_TGT_IMB;
    else if (o >= 22'h38_0000 && o <= 22'h38_00FF) p.t = IMD_TGT_LCTL;
    else if (o >= 22'h3F_7000) begin
      p.t = IMD_TGT_CALIBRATION_SRAM;
      if (CAL_PROTECT[o[15:13]]) begin
        p.er = 1'h1;
        p.x = (!q.from_core || q.overlay) ? IMD_EXC_MCHK : q.data_reloc ? IMD_EXC_DSI : IMD_EXC_NONE;
      end
    end else begin
      p.t = IMD_TGT_RESERVED;
      p.er = 1'h1;
    end
  endfunction
  // outputs seen at an edge were launched by the edge before, so slots are indexed by arrival edge
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int i = 0; i < 8; i++) ex[i] = '0;
    end else begin
      e = ex[cyc % 8];
      ex[cyc % 8] = '0;
      chk("ready", !e.rdy0, REQ_READY);
      chk("ext_valid", e.xv, EXT_VALID);
      chk("rsp_valid", e.rv, RSP.valid);
      if (e.xv) chk("ext_addr", e.xa, EXT_ADDR);
      if (e.rv) begin
        chk("target", e.t, RSP.target);
        chk("offset", e.o, RSP.offset);
        chk("error", e.er, RSP.error);
        chk("exc", e.x, RSP.exc);
      end
      if (REQ_VALID && REQ_READY) begin
        predict(REQ, e);
        ex[(cyc + ((e.t == IMD_TGT_BBU_CTL && e.rv) ? 2 : 1)) % 8] = e;
        if (e.t == IMD_TGT_BBU_CTL && e.rv) ex[(cyc + 1) % 8].rdy0 = 1'h1;
      end
    end
    cyc++;
  end
  initial begin
    RESET = 1'h1;
    BASE_SEL = 3'h0;
    CAL_PROTECT = 8'h00;
    repeat (10) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RESET = 1'h0;
    // table edges eight times over under random bases first, then random traffic biased toward the calibration area
    for (int i = 0; i < 700; i++) begin
      @(negedge CLK_SYS);
      r1 = rnd();
      r2 = rnd();
      BASE_SEL = r1[2:0];
      CAL_PROTECT = r1[10:3];
      off = (i < 208) ? tbl[i % 26] : r2[3] ? {6'h3F, r2[15:0]} : {r1[15:10], r2};
      if (i >= 208 && r2[14:13] == 2'h0) i_core.idle();
      else begin
        i_core.send({(r1[12:11] == 2'h0) ? {r2[6:0], r1[15:13]} : {7'h00, r1[2:0]}, off, r1[14:11]}, ok);
        if (!ok) begin
          n_mismatch++;
          $display("ERROR request_taken expected 1 seen 0");
          break;
        end
      end
    end
    @(negedge CLK_SYS);
    i_core.idle();
    repeat (4) @(posedge CLK_SYS);
    results();
  end
endmodule
